//--- sim/pd_model.sv
`timescale 1ns/1ps
// powered device on the cable: class currents per event and inrush load
module pd_model
  import pse_grant_pkg::*;
(
  input wire logic clk_sys,
  input wire logic clr,
  input wire drive_type port_drive,
  input wire logic [8:0] codes,
  input wire logic stuck,
  output logic [2:0] class_code,
  output logic port_charged_pin,
  output logic port_over_limit_pin,
  output logic [3:0] ev_cnt,
  output logic [3:0] mark_cnt,
  output logic [7:0] cls_len
);
  drive_type drive_q; // drive seen last cycle
  logic [3:0] chg_cnt; // powered cycles, saturating at 8
  logic [2:0] cur_code; // code of the running event
  logic [2:0] last_code; // last code shown
  assign cur_code = (ev_cnt == 4'h1) ? codes[2:0] : (ev_cnt == 4'h2) ? codes[5:3] : codes[8:6];
  // outside events the line must not keep its last value
  assign class_code = (port_drive == DRV_CLASS) ? cur_code : ~last_code;
  // a stuck load never finishes charging
  assign port_charged_pin = !stuck && chg_cnt == 4'h8;
  assign port_over_limit_pin = port_drive == DRV_POWER && !port_charged_pin;
  // count events, marks and class length
  always @(posedge clk_sys) begin
    drive_q <= port_drive;
    if (port_drive == DRV_CLASS) last_code <= cur_code;
    chg_cnt <= (port_drive != DRV_POWER) ? 4'h0 : chg_cnt + {3'h0, chg_cnt != 4'h8};
    if (clr) begin
      ev_cnt <= 4'h0;
      mark_cnt <= 4'h0;
      cls_len <= 8'h0;
    end else begin
      if (port_drive == DRV_CLASS && drive_q != DRV_CLASS) begin
        ev_cnt <= ev_cnt + 4'h1;
        cls_len <= 8'h1;
      end else if (port_drive == DRV_CLASS) cls_len <= cls_len + 8'h1;
      if (port_drive == DRV_MARK && drive_q != DRV_MARK) mark_cnt <= mark_cnt + 4'h1;
    end
  end
endmodule // pd_model

//--- sim/pse_classification_power_grant_tb.sv
`timescale 1ns/1ps
`include "pse_grant_cfg.svh"
module pse_classification_power_grant_tb
  import pse_grant_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, detect_done = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, gate_ramp, gate_full, detect_restart, midspan_mode;
  logic [2:0] detect_result = 3'h0, class_code, power_budget_select = 3'h0;
  logic legacy_pin = 1'b0, dual_signature_enable = 1'b0, clr = 1'b1, stuck = 1'b0;
  logic midspan_pin = 1'b0, port_off_req = 1'b0;
  logic port_charged_pin, port_over_limit_pin;
  logic [8:0] codes = 9'h0;
  logic [3:0] ev_cnt, mark_cnt;
  logic [7:0] cls_len;
  logic [31:0] rd;
  logic [11:0] overload_cut_threshold, current_limit_threshold;
  drive_type port_drive;
  int fails = 0, checked = 0, tnum = 0;
  // 200 mhz system clock
  always #2.5 clk_sys = ~clk_sys;
  // design with shortened event, pause and inrush counts
  pse_classification_power_grant #(.CLASS_CYC(20), .MARK_CYC(8), .INRUSH_CYC(40)) dut (
    .clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .detect_done, .detect_result,
    .class_code, .port_off_req, .midspan_pin, .legacy_pin,
    .dual_signature_enable, .power_budget_select, .port_charged_pin, .port_over_limit_pin,
    .port_drive, .gate_ramp, .gate_full, .detect_restart, .midspan_mode,
    .overload_cut_threshold, .current_limit_threshold);
  // far-side load
  pd_model pd (.clk_sys, .clr, .port_drive, .codes, .stuck, .class_code, .port_charged_pin,
    .port_over_limit_pin, .ev_cnt, .mark_cnt, .cls_len);
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // counts, verdict, stop
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one wait used up its bound
  task automatic tmo();
    fails++;
    $display("[FAIL] wait expected answer seen none");
    end_of_test();
  endtask
  // single ahb-lite word transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    int i;
    int ph;
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    for (ph = 0; ph < 2; ph++) begin
      for (i = 0; i < 50; i++) begin
        @(posedge clk_sys);
        if (hreadyout === 1'b1) break;
      end
      if (i == 50) tmo();
      if (ph == 0) begin
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask
  // wait for inrush start (sel 0) or full gate (sel 1), or a restart pulse
  task automatic wait_until(input logic sel);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (detect_restart === 1'b1 || (sel ? gate_full : gate_ramp) === 1'b1) break;
    end
    if (i == 400) tmo();
  endtask
  // reset with pins, change pins, detect, then follow the grant
  task automatic run_case(input budget_type bud, input logic leg, input logic dual,
      input det_type det, input logic [8:0] cds, input logic [3:0] ev, input logic rs,
      input logic st, input logic [11:0] inr, input logic [11:0] cut, input logic [11:0] lim);
    tnum++;
    @(posedge clk_sys);
    power_budget_select <= bud;
    legacy_pin <= leg;
    dual_signature_enable <= dual;
    midspan_pin <= leg;
    codes <= cds;
    stuck <= st;
    clr <= 1'b1;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    power_budget_select <= bud ^ 3'h1;
    legacy_pin <= ~leg;
    dual_signature_enable <= ~dual;
    midspan_pin <= ~leg;
    clr <= 1'b0;
    repeat (4) @(posedge clk_sys);
    detect_result <= det;
    detect_done <= 1'b1;
    @(posedge clk_sys);
    detect_done <= 1'b0;
    #1 chk("class drive", 32'(port_drive), 32'(DRV_CLASS));
    chk("midspan", 32'(midspan_mode), 32'(leg));
    wait_until(1'b0);
    chk("refused", 32'(detect_restart), 32'(rs));
    if (!rs) begin
      @(posedge clk_sys);
      #1 chk("inrush limit", 32'(current_limit_threshold), 32'(inr));
      chk("ramp drive", 32'({gate_ramp, gate_full, port_drive}), 32'hb);
      wait_until(1'b1);
      chk("inrush timeout", 32'(detect_restart), 32'(st));
      if (!st) begin
        @(posedge clk_sys);
        #1 chk("cut", 32'(overload_cut_threshold), 32'(cut));
        chk("limit", 32'(current_limit_threshold), 32'(lim));
        chk("full gate", 32'(gate_full), 32'h1);
        ahb(1'b0, 32'(`REG_THRESH), 32'h0);
        chk("thresh reg", rd, {4'h0, lim, 4'h0, cut});
        // odd tests turn the port off by software, even ones from outside
        if (tnum[0]) begin
          ahb(1'b1, 32'(`REG_CTRL), 32'h3);
        end else begin
          port_off_req <= 1'b1;
          @(posedge clk_sys);
          port_off_req <= 1'b0;
        end
        wait_until(1'b0);
        @(posedge clk_sys);
        #1 chk("forced off", 32'(port_drive), 32'(DRV_OFF));
      end
    end
    if (ev != 4'h0) begin
      chk("events", 32'(ev_cnt), 32'(ev));
      chk("marks", 32'(mark_cnt), 32'(ev - 4'h1));
      chk("event length", 32'(cls_len), 32'h14);
      ahb(1'b0, 32'(`REG_RESULT), 32'h0);
      chk("result", rd, {23'h0, ev > 4'h2 ? cds[8:6] : 3'h0, ev > 4'h1 ? cds[5:3] : 3'h0,
        cds[2:0]});
    end
    $display("test %0d done", tnum);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    ahb(1'b0, 32'(`REG_CTRL), 32'h0);
    chk("ctrl reset", rd, 32'(`CTRL_EN_RST));
    chk("okay resp", 32'(hresp), 32'h0);
    ahb(1'b1, 32'h10, 32'hffff_ffff);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    ahb(1'b0, 32'h100, 32'h0);
    chk("high unmapped", rd, 32'h0);
    // a good detection is ignored while classification is disabled
    ahb(1'b1, 32'(`REG_CTRL), 32'h0);
    detect_result <= DET_GOOD;
    detect_done <= 1'b1;
    @(posedge clk_sys);
    detect_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("disabled", 32'(port_drive), 32'(DRV_OFF));
    $display("test 0 done");
    run_case(BUD_T1, 1'b0, 1'b0, DET_GOOD, 9'h001, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_3W, `ILIM_STD);
    run_case(BUD_T1, 1'b0, 1'b0, DET_GOOD, 9'h000, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_13W, `ILIM_STD);
    run_case(budget_type'(3'h7), 1'b0, 1'b0, DET_GOOD, 9'h004, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_13W, `ILIM_STD);
    run_case(BUD_T2, 1'b0, 1'b0, DET_GOOD, 9'h002, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_7W, `ILIM_STD);
    run_case(BUD_T2, 1'b0, 1'b0, DET_GOOD, 9'h024, 4'h2, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_25W, `ILIM_25W);
    run_case(BUD_T2, 1'b0, 1'b0, DET_GOOD, 9'h014, 4'h2, 1'b1, 1'b0, 12'h0, 12'h0,
      12'h0);
    run_case(BUD_70, 1'b0, 1'b0, DET_GOOD, 9'h0e4, 4'h3, 1'b1, 1'b0, 12'h0, 12'h0,
      12'h0);
    run_case(BUD_70, 1'b0, 1'b0, DET_GOOD, 9'h0a4, 4'h3, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_70W, `ILIM_70W);
    run_case(BUD_38, 1'b0, 1'b0, DET_GOOD, 9'h024, 4'h3, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_38W, `ILIM_38W);
    run_case(BUD_T1, 1'b1, 1'b0, DET_CPD_HIGH, 9'h001, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH,
      `ICUT_13W, `ILIM_STD);
    run_case(BUD_MAX, 1'b0, 1'b0, DET_GOOD, 9'h001, 4'h1, 1'b0, 1'b0, `ILIM_INRUSH_MAX,
      12'h0, `ILIM_MAX);
    run_case(BUD_52, 1'b0, 1'b1, DET_SIG_LOW, 9'h16d, 4'h0, 1'b0, 1'b0, `ILIM_25W,
      `ICUT_52W, `ILIM_52W);
    run_case(BUD_T1, 1'b0, 1'b0, DET_GOOD, 9'h001, 4'h1, 1'b0, 1'b1, `ILIM_INRUSH,
      12'h0, 12'h0);
    end_of_test();
  end
endmodule // pse_classification_power_grant_tb

//--- src/pse_classification_power_grant.sv
`timescale 1ns/1ps
`include "pse_grant_cfg.svh"
module pse_classification_power_grant
  import pse_grant_pkg::*;
#(
  parameter int CLASS_CYC = `CLASS_EVENT_US * `CLK_MHZ,
  parameter int MARK_CYC = `MARK_PAUSE_US * `CLK_MHZ,
  parameter int INRUSH_CYC = `INRUSH_US * `CLK_MHZ,
  parameter int TMR_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic detect_done,
  input wire logic [2:0] detect_result,
  input wire logic [2:0] class_code,
  input wire logic port_off_req,
  input wire logic midspan_pin,
  input wire logic legacy_pin,
  input wire logic dual_signature_enable,
  input wire logic [2:0] power_budget_select,
  input wire logic port_charged_pin,
  input wire logic port_over_limit_pin,
  output drive_type port_drive,
  output logic gate_ramp,
  output logic gate_full,
  output logic detect_restart,
  output logic midspan_mode,
  output logic [11:0] overload_cut_threshold,
  output logic [11:0] current_limit_threshold
);
  // pin synchronisers: stage one feeds stage two only
  logic [7:0] pin_s1_r;
  logic [7:0] pin_s2_r;
  wire logic [7:0] pins_w = {port_over_limit_pin, port_charged_pin, power_budget_select,
                             dual_signature_enable, legacy_pin, midspan_pin};
  wire logic over_s = pin_s2_r[7]; // current above limit
  wire logic charged_s = pin_s2_r[6]; // output charging complete

  // captured configuration
  logic cfg_done_r; // high from the first edge after reset release
  budget_type budget_r;
  logic legacy_r;
  logic dual_en_r;

  // sequencer state
  state_type state_r;
  state_type state_nxt;
  logic [1:0] ev_r; // class event number
  logic [1:0] ev_nxt;
  alloc_type alloc_r;
  alloc_type alloc_nxt;
  logic dual_det_r; // detection gave too-low with dual enabled
  logic dual_det_nxt;
  logic [8:0] res_r; // raw class codes, event 1 in low bits

  // software registers
  logic en_r; // classification enable
  logic off_r; // one-cycle force-off
  logic wr_pend_r; // write data phase pending
  logic [7:0] wr_addr_r;

  // timer control
  logic tmr_done;
  wire logic tmr_load = (state_nxt != state_r) &&
                        (state_nxt inside {ST_CLASS, ST_MARK, ST_INRUSH});
  wire logic [TMR_W-1:0] tmr_count =
    (state_nxt == ST_CLASS) ? TMR_W'(CLASS_CYC) :
    (state_nxt == ST_MARK) ? TMR_W'(MARK_CYC) : TMR_W'(INRUSH_CYC);

  // maps a first-event standard class to its allocation
  function automatic alloc_type std_alloc(input logic [2:0] c);
    unique case (c[1:0])
      2'h1: std_alloc = AL_3;
      2'h2: std_alloc = AL_7;
      default: std_alloc = AL_13;
    endcase
  endfunction

  // cut and limit threshold pair for an allocation
  function automatic logic [23:0] thr_of(input alloc_type a);
    unique case (a)
      AL_3: thr_of = {`ICUT_3W, `ILIM_STD};
      AL_7: thr_of = {`ICUT_7W, `ILIM_STD};
      AL_13: thr_of = {`ICUT_13W, `ILIM_STD};
      AL_25: thr_of = {`ICUT_25W, `ILIM_25W};
      AL_38: thr_of = {`ICUT_38W, `ILIM_38W};
      AL_52, AL_DUAL: thr_of = {`ICUT_52W, `ILIM_52W};
      AL_70: thr_of = {`ICUT_70W, `ILIM_70W};
      AL_90: thr_of = {`ICUT_90W, `ILIM_90W};
      AL_MAX: thr_of = {12'h000, `ILIM_MAX};
      default: thr_of = 24'h000000;
    endcase
  endfunction

  // detection results that lead into classification
  // too-low passes when dual enabled
  wire logic det_ok = (detect_result == DET_GOOD) ||
                      (dual_en_r && detect_result == DET_SIG_LOW) ||
                      (legacy_r && detect_result inside {DET_CPD_HIGH, DET_SIG_LOW,
                                                         DET_SIG_HIGH});

  // event result decode
  wire logic is_max = budget_r == BUD_MAX;
  wire logic four = class_code == `CLS_FOUR;
  wire logic oc = class_code == `CLS_OC;
  wire logic bad_code = class_code > `CLS_OC;
  // dual needs too-low detect and overcurrent
  wire logic dual_ok = dual_det_r && oc;
  // further events only after class 4
  wire logic more = four && ((ev_r == 2'h1 && budget_r != BUD_T1) ||
                             (ev_r == 2'h2 && budget_r >= BUD_38));
  // third event extended request ranked like the budget
  wire logic [2:0] req_rank = 3'h2 + class_code;
  wire logic over_budget = !is_max && (req_rank > 3'(budget_r));
  wire alloc_type ext_alloc = alloc_type'(4'(AL_38) + {2'b00, class_code[1:0]});
  // dual grant capped by the budget, refused at BUD_38
  wire alloc_type dual_alloc = (budget_r >= BUD_52) ? AL_DUAL :
                               (budget_r == BUD_T1) ? AL_13 :
                               (budget_r == BUD_T2) ? AL_25 : AL_NONE;
  wire alloc_type first_alloc = (four || legacy_r) ? AL_13 : std_alloc(class_code);
  wire alloc_type base_alloc =
    dual_ok ? dual_alloc :
    (oc || bad_code) ? AL_NONE :
    (ev_r == 2'h1) ? first_alloc :
    (ev_r == 2'h2) ? (four ? AL_25 : AL_NONE) :
    four ? AL_25 :
    over_budget ? AL_NONE : ext_alloc;
  // override mode grants maximum to any valid device
  wire alloc_type grant = (is_max && base_alloc != AL_NONE) ? AL_MAX : base_alloc;

  // inrush limit selection
  // inrush limit choice
  wire logic [11:0] inrush_lim = is_max ? `ILIM_INRUSH_MAX :
                                 (alloc_nxt == AL_DUAL && dual_en_r) ?
                                 12'({`ILIM_INRUSH, 1'b0}) : `ILIM_INRUSH;
  wire logic [23:0] thr_w = thr_of(alloc_nxt);
  wire logic live_nxt = state_nxt inside {ST_INRUSH, ST_POWERED};

  // register read decode
  wire logic ahb_go = hsel && hready && htrans[1];
  wire logic hi_zero = haddr[31:8] == 24'h000000;
  wire logic [31:0] status_w = {15'h0000, 1'b0, state_r, ev_r, budget_r, legacy_r,
                                dual_en_r, midspan_mode, dual_det_r, alloc_r};
  wire logic [31:0] rd_w =
    !hi_zero ? 32'h00000000 :
    (haddr[7:0] == `REG_CTRL) ? {31'h00000000, en_r} :
    (haddr[7:0] == `REG_STATUS) ? status_w :
    (haddr[7:0] == `REG_RESULT) ? {23'h000000, res_r} :
    (haddr[7:0] == `REG_THRESH) ?
      {4'h0, current_limit_threshold, 4'h0, overload_cut_threshold} : 32'h00000000;

  // interval timer
  pse_event_timer #(
    .TMR_W(TMR_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    ev_nxt = ev_r;
    alloc_nxt = alloc_r;
    dual_det_nxt = dual_det_r;
    unique case (state_r)
      ST_IDLE: begin
        if (cfg_done_r && en_r && detect_done && det_ok) begin
          state_nxt = ST_CLASS;
          ev_nxt = 2'h1;
          alloc_nxt = AL_NONE;
          dual_det_nxt = dual_en_r && (detect_result == DET_SIG_LOW);
        end
      end
      ST_CLASS: begin
        // sample class current at event end
        if (tmr_done) begin
          if (more) begin
            state_nxt = ST_MARK;
          end else begin
            alloc_nxt = grant;
            state_nxt = (grant != AL_NONE) ? ST_INRUSH : ST_RESTART;
          end
        end
      end
      ST_MARK: begin
        // pause done, next event
        if (tmr_done) begin
          state_nxt = ST_CLASS;
          ev_nxt = ev_r + 2'h1;
        end
      end
      ST_INRUSH: begin
        if (tmr_done) begin
          state_nxt = over_s ? ST_RESTART : ST_POWERED;
        end else if (charged_s && !over_s) begin
          state_nxt = ST_POWERED;
        end
      end
      ST_POWERED: begin
        // port removal from outside or software
        if (port_off_req || off_r) begin
          state_nxt = ST_RESTART;
        end
      end
      ST_RESTART: begin
        state_nxt = ST_IDLE;
        alloc_nxt = AL_NONE;
      end
      default: begin
        state_nxt = ST_RESTART;
      end
    endcase
  end

  // synchronisers run without reset
  always_ff @(posedge clk_sys) begin
    pin_s1_r <= pins_w;
    pin_s2_r <= pin_s1_r;
  end

  // configuration capture once after reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_done_r <= 1'b0;
      budget_r <= BUD_T1;
      legacy_r <= 1'b0;
      dual_en_r <= 1'b0;
      midspan_mode <= 1'b0;
    // sample pins at reset exit only
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'b1;
      budget_r <= (pin_s2_r[5:3] == 3'h7) ? BUD_T1 : budget_type'(pin_s2_r[5:3]);
      dual_en_r <= pin_s2_r[2];
      legacy_r <= pin_s2_r[1];
      midspan_mode <= pin_s2_r[0];
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      ev_r <= 2'h0;
      alloc_r <= AL_NONE;
      dual_det_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ev_r <= ev_nxt;
      alloc_r <= alloc_nxt;
      dual_det_r <= dual_det_nxt;
    end
  end

  // class code log per event
  always_ff @(posedge clk_sys) begin
    if (!rst_n || (state_nxt == ST_CLASS && state_r == ST_IDLE)) begin
      res_r <= 9'h000;
    end else if (state_r == ST_CLASS && tmr_done && ev_r != 2'h0) begin
      res_r[3*(ev_r-1) +: 3] <= class_code;
    end
  end

  // port outputs from next state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_drive <= DRV_OFF;
      gate_ramp <= 1'b0;
      gate_full <= 1'b0;
      detect_restart <= 1'b0;
    end else begin
      port_drive <= (state_nxt == ST_CLASS) ? DRV_CLASS :
                    (state_nxt == ST_MARK) ? DRV_MARK : live_nxt ? DRV_POWER : DRV_OFF;
      gate_ramp <= state_nxt == ST_INRUSH;
      gate_full <= state_nxt == ST_POWERED;
      detect_restart <= state_nxt == ST_RESTART;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overload_cut_threshold <= 12'h000;
      current_limit_threshold <= 12'h000;
    end else begin
      overload_cut_threshold <= live_nxt ? thr_w[23:12] : 12'h000;
      current_limit_threshold <= (state_nxt == ST_INRUSH) ? inrush_lim :
                                 (state_nxt == ST_POWERED) ? thr_w[11:0] : 12'h000;
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= ahb_go && hwrite && hi_zero;
      if (ahb_go) begin
        wr_addr_r <= haddr[7:0];
      end
      if (ahb_go && !hwrite) begin
        hrdata <= rd_w;
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      en_r <= `CTRL_EN_RST;
      off_r <= 1'b0;
    end else begin
      off_r <= wr_pend_r && wr_addr_r == `REG_CTRL && hwdata[`CTRL_OFF_BIT];
      if (wr_pend_r && wr_addr_r == `REG_CTRL) begin
        en_r <= hwdata[`CTRL_EN_BIT];
      end
    end
  end

  // checks on the sequencer
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // classification begins on the next edge
  property p_cls_start;
    (state_r == ST_IDLE && cfg_done_r && en_r && detect_done && det_ok) |=>
      (state_r == ST_CLASS && port_drive == DRV_CLASS && ev_r == 2'h1);
  endproperty
  a_cls_start: assert property (p_cls_start) else $error("no class start");

  // event holds until the timer ends
  property p_ev_hold;
    (state_r == ST_CLASS && !tmr_done) |=> (state_r == ST_CLASS && port_drive == DRV_CLASS);
  endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("class event cut short");

  // class 4 above type 1 goes to mark
  property p_four_mark;
    (state_r == ST_CLASS && tmr_done && ev_r == 2'h1 && class_code == `CLS_FOUR &&
     budget_r != BUD_T1) |=> (state_r == ST_MARK && port_drive == DRV_MARK);
  endproperty
  a_four_mark: assert property (p_four_mark) else $error("no mark after class 4");

  // type 1 budget demotes class 4
  property p_t1_demote;
    (state_r == ST_CLASS && tmr_done && ev_r == 2'h1 && class_code == `CLS_FOUR &&
     budget_r == BUD_T1) |=> (state_r == ST_INRUSH && alloc_r == AL_13 && gate_ramp);
  endproperty
  a_t1_demote: assert property (p_t1_demote) else $error("class 4 not demoted");

  // class 0 gets the class 3 cut threshold
  property p_class0;
    (state_r == ST_CLASS && tmr_done && ev_r == 2'h1 && class_code == `CLS_ZERO &&
     !is_max) |=> (alloc_r == AL_13 && overload_cut_threshold == `ICUT_13W);
  endproperty
  a_class0: assert property (p_class0) else $error("class 0 mis-allocated");

  // class 4 then lower is refused
  property p_bad_pair;
    (state_r == ST_CLASS && tmr_done && ev_r == 2'h2 && class_code < `CLS_FOUR) |=>
      (detect_restart && !gate_ramp) ##1 (state_r == ST_IDLE && !detect_restart);
  endproperty
  a_bad_pair: assert property (p_bad_pair) else $error("bad pair powered");

  property p_over_budget;
    (state_r == ST_CLASS && tmr_done && ev_r == 2'h3 && class_code < `CLS_FOUR &&
     !dual_det_r && over_budget) |=> (state_r == ST_RESTART && alloc_r == AL_NONE);
  endproperty
  a_over_budget: assert property (p_over_budget) else $error("over budget powered");

  property p_inrush_lim;
    (state_r == ST_INRUSH && !is_max && alloc_r != AL_DUAL) |->
      current_limit_threshold == `ILIM_INRUSH;
  endproperty
  a_inrush_lim: assert property (p_inrush_lim) else $error("wrong inrush limit");

  // timeout over limit turns the port off
  property p_inrush_to;
    (state_r == ST_INRUSH && tmr_done && over_s) |=>
      (!gate_ramp && !gate_full && detect_restart && port_drive == DRV_OFF);
  endproperty
  a_inrush_to: assert property (p_inrush_to) else $error("port kept after timeout");

  property p_cfg_hold;
    cfg_done_r |=> ($stable(budget_r) && $stable(legacy_r) && $stable(dual_en_r));
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed");
endmodule // pse_classification_power_grant

//--- src/pse_event_timer.sv
`timescale 1ns/1ps
// one-shot down counter for event, pause and inrush intervals
module pse_event_timer #(
  parameter int TMR_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [TMR_W-1:0] count,
  output logic done
);
  logic [TMR_W-1:0] cnt_r; // remaining cycles
  logic run_r; // interval in progress

  // done is high in the last cycle of the interval
  assign done = run_r && (cnt_r == '0);

  // load restarts; otherwise count down to zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else if (load) begin
      cnt_r <= count - 1'b1;
      run_r <= 1'b1;
    end else if (done) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // pse_event_timer

//--- src/pse_grant_cfg.svh
`ifndef PSE_GRANT_CFG_SVH
`define PSE_GRANT_CFG_SVH
// clock rate in mhz
`define CLK_MHZ 200
// event, mark pause and inrush times in us
`define CLASS_EVENT_US 12000
`define MARK_PAUSE_US 2000
`define INRUSH_US 50000
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESULT 8'h08
`define REG_THRESH 8'h0c
// control fields and reset value
`define CTRL_EN_BIT 0
`define CTRL_OFF_BIT 1
`define CTRL_EN_RST 1'h1
// class codes from the current converter
`define CLS_ZERO 3'h0
`define CLS_FOUR 3'h4
`define CLS_OC 3'h5
// thresholds in ma
`define ICUT_3W 12'h070
`define ICUT_7W 12'h0ce
`define ICUT_13W 12'h177
`define ICUT_25W 12'h27e
`define ICUT_38W 12'h397
`define ICUT_52W 12'h546
`define ICUT_70W 12'h672
`define ICUT_90W 12'h915
`define ILIM_STD 12'h1a9
`define ILIM_25W 12'h352
`define ILIM_38W 12'h4fb
`define ILIM_52W 12'h5d0
`define ILIM_70W 12'h779
`define ILIM_90W 12'h9f6
`define ILIM_MAX 12'hb86
`define ILIM_INRUSH 12'h1a9
`define ILIM_INRUSH_MAX 12'h5dc
`endif

//--- src/pse_grant_pkg.sv
package pse_grant_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLASS = 3'b001,
    ST_MARK = 3'b010,
    ST_INRUSH = 3'b011,
    ST_POWERED = 3'b100,
    ST_RESTART = 3'b101
  } state_type;
  // budget pin encodings, ordered by power
  typedef enum logic [2:0] {
    BUD_T1 = 3'b000,
    BUD_T2 = 3'b001,
    BUD_38 = 3'b010,
    BUD_52 = 3'b011,
    BUD_70 = 3'b100,
    BUD_90 = 3'b101,
    BUD_MAX = 3'b110
  } budget_type;
  // granted allocation
  typedef enum logic [3:0] {
    AL_NONE = 4'b0000,
    AL_3 = 4'b0001,
    AL_7 = 4'b0010,
    AL_13 = 4'b0011,
    AL_25 = 4'b0100,
    AL_38 = 4'b0101,
    AL_52 = 4'b0110,
    AL_70 = 4'b0111,
    AL_90 = 4'b1000,
    AL_DUAL = 4'b1001,
    AL_MAX = 4'b1010
  } alloc_type;
  // port output drive
  typedef enum logic [1:0] {
    DRV_OFF = 2'b00,
    DRV_CLASS = 2'b01,
    DRV_MARK = 2'b10,
    DRV_POWER = 2'b11
  } drive_type;
  // detection result codes
  typedef enum logic [2:0] {
    DET_UNKNOWN = 3'b000,
    DET_SHORT = 3'b001,
    DET_CPD_HIGH = 3'b010,
    DET_SIG_LOW = 3'b011,
    DET_GOOD = 3'b100,
    DET_SIG_HIGH = 3'b101,
    DET_OPEN = 3'b110,
    DET_VOUT = 3'b111
  } det_type;
endpackage
